//--- design/pcce_pkg.sv
// constants, register map and state types of the pwm channel pair engine
// assumes one clock domain and the plain register port of the pair top
package pcce_pkg;
    localparam int NCH = 2;
    localparam int CW = 16;
    localparam int PW = 8;
    localparam int DW = 3;
    localparam int AW = 8;
    localparam int BW = 32;
    localparam int TW = 2;
    localparam int FW = 6;
    localparam int CTW = 8;
    localparam int VW = 4;
    // register byte addresses
    localparam logic [AW-1:0] A_PSC = 8'h00;
    localparam logic [AW-1:0] A_DIV = 8'h04;
    localparam logic [AW-1:0] A_CTL = 8'h08;
    localparam logic [AW-1:0] A_LEN0 = 8'h0C;
    localparam logic [AW-1:0] A_LEN1 = 8'h10;
    localparam logic [AW-1:0] A_THR0 = 8'h14;
    localparam logic [AW-1:0] A_THR1 = 8'h18;
    localparam logic [AW-1:0] A_FLAG = 8'h1C;
    localparam logic [AW-1:0] A_CNT = 8'h20;
    // control byte of each channel
    localparam int C_RUN = 0;
    localparam int C_RELOAD = 1;
    localparam int C_TYPE = 2;
    localparam int C_ASYM = 4;
    localparam int C_HCLD = 5;
    localparam int C_IRQPT = 6;
    localparam int C_OE = 7;
    localparam int DIV_STRIDE = 4;
    // flag word positions, one bit per channel
    localparam int F_CYC = 0;
    localparam int F_UP = 2;
    localparam int F_DN = 4;
    localparam logic [TW-1:0] TYPE_EDGE = 2'h0;
    localparam logic [TW-1:0] TYPE_CENTER = 2'h1;
    localparam logic [TW-1:0] TYPE_PRECISE = 2'h2;
    localparam logic [DW-1:0] DIV_MAX = 3'h4;
    localparam logic [CW-1:0] ZERO = 16'h0000;
    localparam logic [CW-1:0] ONE = 16'h0001;
    localparam logic [CW-1:0] PREC_MIN = 16'h0002;
    localparam logic [PW-1:0] PSC_STEP = 8'h01;
    localparam logic [VW-1:0] DIV_STEP = 4'h1;
    typedef enum logic [3:0] {
        PCCE_IDLE = 4'b0001,
        PCCE_UP = 4'b0010,
        PCCE_HOLD = 4'b0100,
        PCCE_DOWN = 4'b1000
    } pcce_phase_t;
endpackage

//--- design/pcce_div.sv
// per channel power of two divider of the shared prescaler tick
// assumes pre_tick is a one cycle pulse on mclk
`timescale 1ns/10ps
module pcce_div (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // prescaled tick and selection
    input wire logic pre_tick,
    input wire logic [pcce_pkg::DW-1:0] divider_select,
    // divided tick
    output logic tick
);
    import pcce_pkg::*;

    typedef struct packed {
        logic [VW-1:0] cnt;
    } pcce_div_state_t;

    pcce_div_state_t r;
    pcce_div_state_t n;
    logic [DW-1:0] sel;
    logic [VW-1:0] mask;

    ////////////////////////////////////////////////////////////////////
    // codes above the largest divider clamp to 1/16
    always_comb begin
        n = r;
        sel = (divider_select > DIV_MAX) ? DIV_MAX : divider_select;
        mask = VW'((5'h01 << sel) - 5'h01);
        tick = pre_tick && ((r.cnt & mask) == mask);
        if (pre_tick) begin
            n.cnt = r.cnt + DIV_STEP;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // pcce_div

//--- design/pcce_pair.sv
// one even/odd pwm channel pair: shared prescaler, counters, registers
// assumes a same clock register master that never waits
`timescale 1ns/10ps
module pcce_pair (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [pcce_pkg::AW-1:0] reg_addr,
    input wire logic [pcce_pkg::BW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pcce_pkg::BW-1:0] reg_rdata,
    // pins toward the power switches
    output logic [pcce_pkg::NCH-1:0] channel_output
);
    import pcce_pkg::*;

    typedef struct packed {
        logic [PW-1:0] psc;
        logic [PW-1:0] psc_cnt;
        logic [NCH-1:0][DW-1:0] divsel;
        logic [NCH-1:0][CTW-1:0] ctl;
        logic [NCH-1:0][CW-1:0] len_buf;
        logic [NCH-1:0][CW-1:0] thr_buf;
        logic [NCH-1:0][CW-1:0] dthr_buf;
        logic [NCH-1:0][CW-1:0] len;
        logic [NCH-1:0][CW-1:0] thr;
        logic [NCH-1:0][CW-1:0] dthr;
        logic [NCH-1:0][CW-1:0] cnt;
        pcce_phase_t [NCH-1:0] phase;
        logic [NCH-1:0] done;
        logic [FW-1:0] flags;
        logic [NCH-1:0] pin;
        logic [BW-1:0] rdata;
    } pcce_state_t;

    pcce_state_t r;
    pcce_state_t n;
    logic pre_tick;
    logic [NCH-1:0] tick;

    ////////////////////////////////////////////////////////////////////
    // shared prescaler, one divider per channel
    assign pre_tick = (r.psc_cnt == r.psc);

    for (genvar g = 0; g < NCH; g++) begin : g_div
        pcce_div u_div (
            .mclk(mclk),
            .reset(reset),
            .pre_tick(pre_tick),
            .divider_select(r.divsel[g]),
            .tick(tick[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [CTW-1:0] c;
        logic [CTW-1:0] nc;
        logic [TW-1:0] ty;
        logic edge_t;
        logic prec;
        logic asym;
        logic load;
        logic wave;
        logic [CW-1:0] ad;
        logic [CW-1:0] half;
        logic [CW-1:0] top;
        logic [CW-1:0] nxt;
        logic [CW-1:0] lk;
        logic [CW-1:0] tk;
        logic [CW-1:0] dk;
        logic [CW-1:0] k;
        logic [FW-1:0] fset;
        logic [FW-1:0] fclr;
        c = '0;
        nc = '0;
        ty = '0;
        edge_t = 1'b0;
        prec = 1'b0;
        asym = 1'b0;
        load = 1'b0;
        wave = 1'b0;
        ad = '0;
        half = '0;
        top = '0;
        nxt = '0;
        lk = '0;
        tk = '0;
        dk = '0;
        k = '0;
        fset = '0;
        fclr = '0;
        n = r;
        n.psc_cnt = pre_tick ? '0 : r.psc_cnt + PSC_STEP;

        for (int i = 0; i < NCH; i++) begin
            c = r.ctl[i];
            ty = c[C_TYPE +: TW];
            // type code 3 falls back to edge aligned
            edge_t = (ty != TYPE_CENTER) && (ty != TYPE_PRECISE);
            prec = (ty == TYPE_PRECISE);
            asym = c[C_ASYM] && !edge_t;
            ad = asym ? r.dthr[i] : r.thr[i];
            half = {1'b0, r.len[i][CW-1:1]};
            top = prec ? half : r.len[i];
            load = 1'b0;
            if (!c[C_RUN]) begin
                n.phase[i] = PCCE_IDLE;
                n.done[i] = 1'b0;
                n.cnt[i] = ZERO;
            end else if (r.phase[i] == PCCE_IDLE) begin
                // first cycle takes the buffered values
                load = 1'b1;
                n.phase[i] = edge_t ? PCCE_DOWN : PCCE_UP;
                n.cnt[i] = edge_t ? r.len_buf[i] : ZERO;
            end else if (tick[i] && !r.done[i]) begin
                case (r.phase[i])
                    PCCE_DOWN: begin
                        if (r.len[i] == ZERO ||
                            (prec && r.len[i] < PREC_MIN)) begin
                            n.cnt[i] = r.cnt[i];
                        end else if (r.cnt[i] == (prec ? ONE : ZERO)) begin
                            if (!edge_t && !c[C_IRQPT]) begin
                                fset[F_CYC + i] = 1'b1;
                            end
                            if (c[C_RELOAD]) begin
                                load = 1'b1;
                                n.cnt[i] = edge_t ? r.len_buf[i] : ZERO;
                                n.phase[i] = edge_t ? PCCE_DOWN : PCCE_UP;
                            end else begin
                                // one shot: stays until run drops
                                n.done[i] = 1'b1;
                            end
                        end else begin
                            nxt = r.cnt[i] - ONE;
                            n.cnt[i] = nxt;
                            if (edge_t) begin
                                fset[F_DN + i] = (nxt == r.thr[i]);
                                fset[F_CYC + i] = (nxt == ZERO);
                            end else if (prec) begin
                                fset[F_DN + i] = (nxt == ad + ONE);
                            end else begin
                                fset[F_DN + i] = (nxt == ad);
                            end
                        end
                    end
                    PCCE_UP: begin
                        if (r.len[i] == ZERO ||
                            (prec && r.len[i] < PREC_MIN)) begin
                            n.cnt[i] = r.cnt[i];
                        end else if (r.cnt[i] == top) begin
                            if (c[C_IRQPT]) begin
                                fset[F_CYC + i] = 1'b1;
                            end
                            if (c[C_HCLD]) begin
                                load = 1'b1;
                                if (!prec) begin
                                    n.cnt[i] = r.len_buf[i];
                                end
                            end
                            if (prec && r.len[i][0]) begin
                                // odd length keeps the top value twice
                                n.phase[i] = PCCE_HOLD;
                            end else begin
                                n.phase[i] = PCCE_DOWN;
                                if (prec) begin
                                    n.cnt[i] = r.cnt[i] - ONE;
                                end
                            end
                        end else begin
                            nxt = r.cnt[i] + ONE;
                            n.cnt[i] = nxt;
                            fset[F_UP + i] = (nxt == r.thr[i]);
                        end
                    end
                    PCCE_HOLD: begin
                        n.phase[i] = PCCE_DOWN;
                        n.cnt[i] = r.cnt[i] - ONE;
                    end
                    default: begin
                        n.phase[i] = PCCE_IDLE;
                    end
                endcase
            end
            if (load) begin
                n.len[i] = r.len_buf[i];
                n.thr[i] = r.thr_buf[i];
                n.dthr[i] = r.dthr_buf[i];
            end

            // waveform from the next counter state, so the pin is a flop
            lk = n.len[i];
            tk = n.thr[i];
            dk = asym ? n.dthr[i] : n.thr[i];
            k = n.cnt[i];
            if (n.phase[i] == PCCE_IDLE || n.done[i]) begin
                wave = 1'b0;
            end else if (edge_t) begin
                if (lk == ZERO || tk == ZERO) begin
                    wave = 1'b0;
                end else if (tk >= lk) begin
                    wave = 1'b1;
                end else begin
                    wave = (k <= tk);
                end
            end else if (lk == ZERO || tk >= lk) begin
                wave = 1'b0;
            end else if (tk == ZERO) begin
                wave = 1'b1;
            end else if (n.phase[i] == PCCE_DOWN) begin
                if (prec) begin
                    wave = ({1'b0, k} > ({1'b0, dk} + 17'h00001));
                end else begin
                    wave = (k > dk);
                end
            end else begin
                wave = (k > tk);
            end
            // pin gated by the software output enable
            n.pin[i] = wave && c[C_OE];
        end

        ////////////////////////////////////////////////////////////////
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                A_PSC: begin
                    n.psc = reg_wdata[PW-1:0];
                end
                A_DIV: begin
                    for (int i = 0; i < NCH; i++) begin
                        n.divsel[i] = reg_wdata[i*DIV_STRIDE +: DW];
                    end
                end
                A_CTL: begin
                    for (int i = 0; i < NCH; i++) begin
                        nc = reg_wdata[i*CTW +: CTW];
                        n.ctl[i] = nc;
                        if (nc[C_TYPE +: TW] != r.ctl[i][C_TYPE +: TW] ||
                            nc[C_RELOAD] != r.ctl[i][C_RELOAD]) begin
                            n.len_buf[i] = ZERO;
                            n.thr_buf[i] = ZERO;
                            n.len[i] = ZERO;
                            n.thr[i] = ZERO;
                        end
                    end
                end
                A_LEN0: begin
                    n.len_buf[0] = reg_wdata[CW-1:0];
                end
                A_LEN1: begin
                    n.len_buf[1] = reg_wdata[CW-1:0];
                end
                A_THR0: begin
                    n.thr_buf[0] = reg_wdata[CW-1:0];
                    n.dthr_buf[0] = reg_wdata[BW-1:CW];
                end
                A_THR1: begin
                    n.thr_buf[1] = reg_wdata[CW-1:0];
                    n.dthr_buf[1] = reg_wdata[BW-1:CW];
                end
                A_FLAG: begin
                    fclr = reg_wdata[FW-1:0];
                end
                default: begin
                end
            endcase
        end
        // a set in the clearing cycle wins
        n.flags = (r.flags & ~fclr) | fset;

        ////////////////////////////////////////////////////////////////
        // read data stands one cycle, zero otherwise
        n.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                A_PSC: n.rdata = BW'(r.psc);
                A_DIV: n.rdata = {25'h0000000, r.divsel[1], 1'b0,
                                  r.divsel[0]};
                A_CTL: n.rdata = BW'(r.ctl);
                A_LEN0: n.rdata = BW'(r.len_buf[0]);
                A_LEN1: n.rdata = BW'(r.len_buf[1]);
                A_THR0: n.rdata = {r.dthr_buf[0], r.thr_buf[0]};
                A_THR1: n.rdata = {r.dthr_buf[1], r.thr_buf[1]};
                A_FLAG: n.rdata = BW'(r.flags);
                A_CNT: n.rdata = {r.cnt[1], r.cnt[0]};
                default: n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
            for (int i = 0; i < NCH; i++) begin
                r.phase[i] <= PCCE_IDLE;
            end
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign channel_output = r.pin;
endmodule // pcce_pair

//--- sim/pcce_pair_props.sv
// checker for one pwm channel pair: register port and pin gating
// assumes it sees only the ports of pcce_pair, single mclk domain
`timescale 1ns/10ps
module pcce_pair_props (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [pcce_pkg::AW-1:0] reg_addr,
    input wire logic [pcce_pkg::BW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pcce_pkg::BW-1:0] reg_rdata,
    // pins
    input wire logic [pcce_pkg::NCH-1:0] channel_output
);
    import pcce_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // shadows of channel 0 buffers, rebuilt from bus traffic only
    logic rd_d;
    logic run_d;
    logic [AW-1:0] ra_d;
    logic [7:0] ctl_sh;
    logic [15:0] len_sh;
    logic [31:0] thr_sh;
    logic [5:0] seen;
    logic wr_ctl;
    logic wr_flag;
    logic mchg;
    assign wr_ctl = reg_wr && reg_addr == A_CTL;
    assign wr_flag = reg_wr && reg_addr == A_FLAG;
    assign mchg = wr_ctl && reg_wdata[3:1] != ctl_sh[3:1];
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_d <= 1'b0;
            run_d <= 1'b0;
            ra_d <= 8'h00;
            ctl_sh <= 8'h00;
            len_sh <= 16'h0000;
            thr_sh <= 32'h0000_0000;
            seen <= 6'h00;
        end else begin
            rd_d <= reg_rd;
            ra_d <= reg_addr;
            run_d <= ctl_sh[C_RUN];
            if (wr_ctl) begin
                ctl_sh <= reg_wdata[7:0];
            end
            if (mchg) begin
                len_sh <= 16'h0000;
                thr_sh[15:0] <= 16'h0000;
            end else if (reg_wr && reg_addr == A_LEN0) begin
                len_sh <= reg_wdata[15:0];
            end else if (reg_wr && reg_addr == A_THR0) begin
                thr_sh <= reg_wdata;
            end
            // a clear landing with the capture must not count as seen
            if (rd_d && ra_d == A_FLAG) begin
                seen <= reg_rdata[5:0] & ~(wr_flag ? reg_wdata[5:0] : 6'h00);
            end else if (wr_flag) begin
                seen <= seen & ~reg_wdata[5:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_RDATA_QUIET: assert property ((!rd_d || ra_d > A_CNT) |->
        reg_rdata == 32'h0000_0000) else $error("read data not quiet");
    AST_LEN_BUFFER: assert property (rd_d && ra_d == A_LEN0 |->
        reg_rdata[15:0] == len_sh) else $error("length buffer wrong");
    AST_THR_BUFFER: assert property (rd_d && ra_d == A_THR0 |->
        reg_rdata == thr_sh) else $error("threshold buffer wrong");
    AST_FLAG_STICKY: assert property (rd_d && ra_d == A_FLAG |->
        (reg_rdata[5:0] & seen) == seen) else $error("flag lost");
    AST_FLAG_WIDTH: assert property (rd_d && ra_d == A_FLAG |->
        reg_rdata[31:6] == 26'h0) else $error("flag word too wide");
    AST_OE_GATE: assert property (!ctl_sh[C_OE] |=>
        !channel_output[0]) else $error("pin driven without enable");
    AST_IDLE_OUT: assert property (!ctl_sh[C_RUN] [*2] |->
        !channel_output[0]) else $error("idle pin not low");
    AST_IDLE_CNT: assert property (!run_d && !ctl_sh[C_RUN] && reg_rd &&
        reg_addr == A_CNT |=> reg_rdata[15:0] == 16'h0000)
        else $error("idle counter not zero");
    COV_RISE: cover property ($rose(channel_output[0]));
    COV_DOWN_FLAG: cover property (rd_d && ra_d == A_FLAG && reg_rdata[4]);
    COV_MODE: cover property (mchg);
endmodule // pcce_pair_props

bind pcce_pair pcce_pair_props u_props (
    .mclk(mclk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .channel_output(channel_output)
);

//--- sim/pcce_gate_model.sv
// gate driver model: measures high and low widths on one pwm pin
// assumes the pin is a registered level sampled on rising mclk
`timescale 1ns/10ps
module pcce_gate_model (
    // clock
    input wire logic mclk,
    // pin from the pwm pair
    input wire logic gate_in,
    // last full widths in mclk cycles, and rising edge count
    output int hi_w,
    output int lo_w,
    output int rises
);
    int run_len;
    logic last;
    initial begin
        hi_w = 0;
        lo_w = 0;
        rises = 0;
        run_len = 0;
        last = 1'b0;
    end
    // passive listener: a gate only loads the pin, it never drives it
    always @(posedge mclk) begin
        if (gate_in !== last) begin
            if (last === 1'b1) begin
                hi_w <= run_len;
            end else begin
                lo_w <= run_len;
            end
            if (gate_in === 1'b1) begin
                rises <= rises + 1;
            end
            run_len <= 1;
        end else begin
            run_len <= run_len + 1;
        end
        last <= gate_in;
    end
endmodule // pcce_gate_model

//--- sim/pcce_pair_tb_top.sv
// testbench of one pwm channel pair, channel 0 watched by a gate model
// assumes mclk 10 MHz and a never waiting register master
`timescale 1ns/10ps
module pcce_pair_tb_top;
    import pcce_pkg::*;
    logic mclk, reset, reg_wr, reg_rd;
    logic [AW-1:0] reg_addr;
    logic [BW-1:0] reg_wdata, reg_rdata, rv;
    logic [NCH-1:0] channel_output;
    int num_errors, n_checks, hi_w, lo_w, rises, r0;
    pcce_pair dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .channel_output(channel_output));
    pcce_gate_model gate0 (.mclk(mclk), .gate_in(channel_output[0]),
        .hi_w(hi_w), .lo_w(lo_w), .rises(rises));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobes drop for one idle edge so no task re-raises in the same step
    task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [BW-1:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        wr(A_LEN0, 32'h0000_1234);
        rd(A_LEN0, rv);
        check("length buffer", 32'h0000_1234, {16'h0000, rv[15:0]});
        wr(A_THR0, 32'h0005_0003);
        wr(A_CTL, 32'h0000_0002);
        rd(A_LEN0, rv);
        check("length cleared", 32'h0000_0000, {16'h0000, rv[15:0]});
        rd(A_THR0, rv);
        check("threshold cleared", 32'h0005_0000, rv);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, rv);
        check("unmapped read", 32'h0000_0000, rv);
    endtask
    // mode first, then values, then run: the order software must keep
    task automatic t_cfg(input logic [7:0] mode, input logic [15:0] len,
                         input logic [31:0] thr, input logic [7:0] go);
        wr(A_CTL, {24'h000000, mode});
        wr(A_LEN0, {16'h0000, len});
        wr(A_THR0, thr);
        wr(A_FLAG, 32'h0000_003F);
        r0 = rises;
        wr(A_CTL, {24'h000000, mode | go});
    endtask
    task automatic t_widths(input string what, input int hi, input int lo);
        int n;
        n = rises + 3;
        for (int i = 0; i < 3000 && rises < n; i++) @(posedge mclk);
        check({what, " rises"}, n, rises);
        check({what, " high"}, hi, hi_w);
        check({what, " low"}, lo, lo_w);
    endtask
    task automatic t_stop(input logic [7:0] mode, input logic [5:0] flg);
        wr(A_CTL, {24'h000000, mode});
        rd(A_FLAG, rv);
        check("flags set", {26'h0, flg}, rv);
        check("idle pins", 32'h0000_0000, {30'h0, channel_output});
        rd(A_CNT, rv);
        check("idle counter", 32'h0000_0000, rv);
        wr(A_FLAG, 32'h0000_003F);
        rd(A_FLAG, rv);
        check("flags cleared", 32'h0000_0000, rv);
    endtask
    // center load with the period flag at the top: count jumps to new length
    task automatic t_center_load();
        t_cfg(8'h66, 16'h0004, 32'h0000_0001, 8'h81);
        wr(A_LEN0, 32'h0000_0006);
        repeat (4) @(posedge mclk);
        rd(A_FLAG, rv);
        check("center flags", 32'h0000_0005, rv);
        rd(A_CNT, rv);
        check("center loaded count", 32'h0000_0003, rv);
        t_stop(8'h66, 6'h15);
    endtask
    // odd channel: threshold above length keeps its pin high
    task automatic t_odd_channel();
        wr(A_CTL, 32'h0000_0200);
        wr(A_LEN1, 32'h0000_0004);
        wr(A_THR1, 32'h0000_0009);
        rd(A_LEN1, rv);
        check("odd length buffer", 32'h0000_0004, rv);
        wr(A_CTL, 32'h0000_8300);
        repeat (10) @(posedge mclk);
        check("odd pin high", 32'h1, {31'h0, channel_output[1]});
        wr(A_CTL, 32'h0000_0200);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        num_errors = 0;
        n_checks = 0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_cfg(8'h02, 16'h0004, 32'h0000_0001, 8'h01);
        repeat (60) @(posedge mclk);
        check("gated pin rises", 32'h0, rises - r0);
        t_stop(8'h02, 6'h11);
        t_cfg(8'h02, 16'h0004, 32'h0000_0001, 8'h81);
        t_widths("edge", 2, 3);
        wr(A_THR0, 32'h0000_0002);
        t_widths("edge rebuffered", 3, 2);
        t_stop(8'h02, 6'h11);
        t_cfg(8'h00, 16'h0004, 32'h0000_0001, 8'h81);
        repeat (80) @(posedge mclk);
        check("one shot rises", 32'h1, rises - r0);
        t_cfg(8'h06, 16'h0004, 32'h0000_0001, 8'h81);
        t_widths("center", 6, 4);
        t_stop(8'h06, 6'h15);
        t_cfg(8'h16, 16'h0006, 32'h0003_0001, 8'h81);
        t_widths("asymmetric", 8, 6);
        t_stop(8'h16, 6'h15);
        t_cfg(8'h0A, 16'h0009, 32'h0000_0001, 8'h81);
        t_widths("precise", 5, 4);
        t_stop(8'h0A, 6'h15);
        t_center_load();
        t_odd_channel();
        wr(A_PSC, 32'h0000_0001);
        wr(A_DIV, 32'h0000_0001);
        rd(A_DIV, rv);
        check("divider select", 32'h0000_0001, rv);
        rd(A_PSC, rv);
        check("prescale", 32'h0000_0001, rv);
        t_cfg(8'h02, 16'h0004, 32'h0000_0001, 8'h81);
        t_widths("prescaled", 8, 12);
        t_stop(8'h02, 6'h11);
        finish_test();
    end
    // whole run is well under a thousand cycles; this bound only cuts a hang
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
endmodule // pcce_pair_tb_top
